// ===== core/mst_startup_limit_config.sv
// start-up profile and limit register bank with open-loop start-up sequencer
// Summary of operation
// - range bit 14 selects fast table at 0, slow table at 1
// - fast second-order codes map 57 down to 0 Hz/s^2
// - slow second-order codes map 0.22 down to 0 Hz/s^2, halving
// - fast first-order codes map 76 down to 0.3 Hz/s
// - slow first-order codes map 4.8 down to 0.019 Hz/s
// - handover threshold with top bit 0 is n times 0.8 Hz
// - handover threshold with top bit 1 is (n+1) times 12.8 Hz
// - align field picks 5.3 s down to 0.04 s, halving each step
// - profile bit 15 is reserved, read-only, reads zero
// - limit register sits at 0x94, resets to zero, fully read-write
// - limit bits 13..8 each enable one lock-detect condition
// - soft current limit is n times 0.2 A, zero disables
// - over-temperature cap selects the soft limit, 1 A, 1.6 A or 2 A
// - hard lock limit from a four-entry table at bit 0 = 0, (n+1) times 0.4 A at bit 0 = 1
`timescale 1ns/1ps
module mst_startup_limit_config
  import mst_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  input  wire logic        startReq,
  input  wire logic        stopReq,
  output logic             alignActive,
  output logic             rampActive,
  output logic             closedLoop,
  output logic      [47:0] openLoopSpeed,
  output logic      [5:0]  lockEnable,
  output logic      [11:0] softLimitMa,
  output logic      [11:0] overtempCapMa,
  output logic      [11:0] hardLimitMa
);
  localparam int          RD_LAT     = 1;
  localparam logic [14:0] TICK_LAST  = 15'(TICK_CYCLES - 1);

  logic [15:0] profileReg;
  logic [15:0] limitReg;
  logic [15:0] next_profileReg;
  logic [15:0] next_limitReg;
  logic [15:0] next_regRdData;
  logic [11:0] decSoft;
  logic [11:0] decCap;
  logic [11:0] decHard;
  logic [5:0]  next_lockEnable;

  mst_profile_if profIf ();

  mst_profile_decode u_profile (
    .profileReg (profileReg),
    .prof       (profIf.src)
  );

  mst_limit_decode u_limit (
    .limitReg (limitReg),
    .softMa   (decSoft),
    .capMa    (decCap),
    .hardMa   (decHard)
  );

  // register bank
  always_comb begin
    next_profileReg = profileReg;
    next_limitReg   = limitReg;
    next_regRdData  = regRdData;
    if (regWrEn) begin
      if (regAddr == ADDR_PROFILE) begin
        next_profileReg = regWrData & PROFILE_WMASK;
      end else if (regAddr == ADDR_LIMITS) begin
        next_limitReg = regWrData;
      end
    end
    if (regRdEn) begin
      if (regAddr == ADDR_PROFILE) begin
        next_regRdData = profileReg & PROFILE_WMASK;
      end else if (regAddr == ADDR_LIMITS) begin
        next_regRdData = limitReg;
      end else begin
        next_regRdData = READ_UNMAPPED;
      end
    end
    next_lockEnable = limitReg[LIM_LOCK_LSB +: 6];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      profileReg    <= PROFILE_RESET;
      limitReg      <= LIMITS_RESET;
      regRdData     <= 16'h0000;
      lockEnable    <= 6'h00;
      softLimitMa   <= 12'h000;
      overtempCapMa <= 12'h000;
      hardLimitMa   <= 12'h000;
    end else begin
      profileReg    <= next_profileReg;
      limitReg      <= next_limitReg;
      regRdData     <= next_regRdData;
      lockEnable    <= next_lockEnable;
      softLimitMa   <= decSoft;
      overtempCapMa <= decCap;
      hardLimitMa   <= decHard;
    end
  end

  // start-up sequencer
  mst_state_e  state;
  mst_state_e  next_state;
  logic [14:0] tickCnt;
  logic [14:0] next_tickCnt;
  logic [12:0] alignMs;
  logic [12:0] next_alignMs;
  logic [47:0] slope2;
  logic [47:0] next_slope2;
  logic [47:0] next_speed;
  logic [47:0] thrUnits;
  logic        tick;

  always_comb begin
    tick         = (tickCnt == TICK_LAST);
    thrUnits     = 48'(48'(profIf.handoverDhz) * SPEED_PER_DHZ);
    next_state   = state;
    next_tickCnt = tick ? 15'h0000 : 15'(tickCnt + 15'h0001);
    next_alignMs = alignMs;
    next_slope2  = slope2;
    next_speed   = openLoopSpeed;
    case (state)
      ST_IDLE: begin
        next_tickCnt = 15'h0000;
        if (startReq) begin
          next_state   = ST_ALIGN;
          next_alignMs = 13'h0000;
          next_slope2  = 48'h0;
          next_speed   = 48'h0;
        end
      end
      ST_ALIGN: begin
        if (tick) begin
          next_alignMs = 13'(alignMs + 13'h0001);
          if (13'(alignMs + 13'h0001) >= profIf.alignMs) begin
            next_state = ST_RAMP;
          end
        end
      end
      ST_RAMP: begin
        if (openLoopSpeed >= thrUnits) begin
          next_state = ST_CLOSED;
        end else if (tick) begin
          next_speed  = 48'(openLoopSpeed + 48'(profIf.accel1) * 48'(ACC1_SCALE) + slope2);
          next_slope2 = 48'(slope2 + 48'(profIf.accel2));
        end
      end
      ST_CLOSED: begin
        next_tickCnt = 15'h0000;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (stopReq) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state         <= ST_IDLE;
      tickCnt       <= 15'h0000;
      alignMs       <= 13'h0000;
      slope2        <= 48'h0;
      openLoopSpeed <= 48'h0;
    end else begin
      state         <= next_state;
      tickCnt       <= next_tickCnt;
      alignMs       <= next_alignMs;
      slope2        <= next_slope2;
      openLoopSpeed <= next_speed;
    end
  end

  assign alignActive = (state == ST_ALIGN);
  assign rampActive  = (state == ST_RAMP);
  assign closedLoop  = (state == ST_CLOSED);

  // checks
  sequence s_prof_write;
    regWrEn && regAddr == ADDR_PROFILE;
  endsequence

  sequence s_align_done;
    state == ST_ALIGN && tick && 13'(alignMs + 13'h0001) >= profIf.alignMs && !stopReq;
  endsequence

  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    regRdEn && regAddr == ADDR_PROFILE |-> ##RD_LAT !regRdData[PROF_RSV_BIT])
    else $error("reserved profile bit read as one");

  a_profile_store: assert property (@(posedge clk) disable iff (!resetn)
    s_prof_write |=> profileReg == ($past(regWrData) & PROFILE_WMASK) && !profileReg[15])
    else $error("profile register did not store write");

  a_limit_rdback: assert property (@(posedge clk) disable iff (!resetn)
    regWrEn && regAddr == ADDR_LIMITS ##1 regRdEn && regAddr == ADDR_LIMITS && !regWrEn
    |=> regRdData == $past(regWrData, 2))
    else $error("limit register read back mismatch");

  a_lock_follow: assert property (@(posedge clk) disable iff (!resetn)
    ##1 lockEnable == $past(limitReg[13:8]))
    else $error("lock enables do not follow register");

  a_soft_scale: assert property (@(posedge clk) disable iff (!resetn)
    ##1 softLimitMa == 12'($past(limitReg[7:4]) * 12'd200))
    else $error("soft current limit scale wrong");

  a_cap_fallback: assert property (@(posedge clk) disable iff (!resetn)
    ##1 $past(limitReg[15:14]) == 2'h0 |-> overtempCapMa == softLimitMa)
    else $error("temperature cap zero does not use soft limit");

  a_hard_range: assert property (@(posedge clk) disable iff (!resetn)
    ##1 $past(limitReg[0]) && $past(limitReg[3:1]) == 3'h7 |-> hardLimitMa == 12'd3200)
    else $error("hard limit top code wrong");

  a_threshold_hi: assert property (@(posedge clk) disable iff (!resetn)
    profileReg[7:3] == 5'h1F |-> profIf.handoverDhz == 12'd2048)
    else $error("handover threshold top code wrong");

  a_align_exit: assert property (@(posedge clk) disable iff (!resetn)
    s_align_done |=> rampActive && alignMs == profIf.alignMs)
    else $error("align phase did not end on time");

  a_start_align: assert property (@(posedge clk) disable iff (!resetn)
    state == ST_IDLE && startReq && !stopReq |=> alignActive && openLoopSpeed == 48'h0)
    else $error("start did not enter align");

  a_handover: assert property (@(posedge clk) disable iff (!resetn)
    rampActive && openLoopSpeed >= thrUnits && !stopReq |=> closedLoop)
    else $error("handover to closed loop missed");

  sequence s_lim_write;
    regWrEn && regAddr == ADDR_LIMITS;
  endsequence

  sequence s_other_write;
    regWrEn && regAddr != ADDR_PROFILE && regAddr != ADDR_LIMITS;
  endsequence

  sequence s_other_read;
    regRdEn && regAddr != ADDR_PROFILE && regAddr != ADDR_LIMITS;
  endsequence

  a_limit_store: assert property (@(posedge clk) disable iff (!resetn)
    s_lim_write |=> limitReg == $past(regWrData))
    else $error("limit register did not store write");

  a_other_write: assert property (@(posedge clk) disable iff (!resetn)
    s_other_write |=> $stable(profileReg) && $stable(limitReg))
    else $error("write to unmapped address changed a register");

  a_other_read: assert property (@(posedge clk) disable iff (!resetn)
    s_other_read |=> regRdData == READ_UNMAPPED)
    else $error("unmapped read returned nonzero data");

  a_read_hold: assert property (@(posedge clk) disable iff (!resetn)
    !regRdEn |=> $stable(regRdData))
    else $error("read data changed without a read");

  a_profile_rdback: assert property (@(posedge clk) disable iff (!resetn)
    regRdEn && regAddr == ADDR_PROFILE |=> regRdData == ($past(profileReg) & PROFILE_WMASK))
    else $error("profile read back mismatch");

  a_fast_second: assert property (@(posedge clk) disable iff (!resetn)
    !profileReg[14] && profileReg[13:11] == 3'h0 |-> profIf.accel2 == 20'h8B290)
    else $error("fast second-order top code wrong");

  a_slow_second: assert property (@(posedge clk) disable iff (!resetn)
    profileReg[14] && profileReg[13:11] == 3'h0 |-> profIf.accel2 == 20'h00898)
    else $error("slow second-order top code wrong");

  a_fast_first: assert property (@(posedge clk) disable iff (!resetn)
    !profileReg[14] && profileReg[10:8] == 3'h0 |-> profIf.accel1 == 17'h128E0)
    else $error("fast first-order top code wrong");

  a_slow_first: assert property (@(posedge clk) disable iff (!resetn)
    profileReg[14] && profileReg[10:8] == 3'h0 |-> profIf.accel1 == 17'h012C0)
    else $error("slow first-order top code wrong");

  a_threshold_lo: assert property (@(posedge clk) disable iff (!resetn)
    profileReg[7:3] == 5'h01 |-> profIf.handoverDhz == 12'h008)
    else $error("handover threshold low code wrong");

  a_align_long: assert property (@(posedge clk) disable iff (!resetn)
    profileReg[2:0] == 3'h0 |-> profIf.alignMs == 13'h14B4)
    else $error("longest align time wrong");

  a_stop_idle: assert property (@(posedge clk) disable iff (!resetn)
    stopReq |=> state == ST_IDLE)
    else $error("stop did not return to idle");

  a_closed_hold: assert property (@(posedge clk) disable iff (!resetn)
    closedLoop && !stopReq |=> closedLoop)
    else $error("closed loop left without stop");
endmodule : mst_startup_limit_config

// ===== core/mst_pkg.sv
// constants for the start-up profile and limit configuration block
package mst_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 16;
  localparam logic [7:0]  ADDR_PROFILE   = 8'h93;
  localparam logic [7:0]  ADDR_LIMITS    = 8'h94;
  localparam logic [15:0] PROFILE_RESET  = 16'h0000;
  localparam logic [15:0] LIMITS_RESET   = 16'h0000;
  localparam logic [15:0] PROFILE_WMASK  = 16'h7FFF;
  localparam logic [15:0] READ_UNMAPPED  = 16'h0000;
  localparam int          PROF_RSV_BIT   = 15;
  localparam int          PROF_RANGE_BIT = 14;
  localparam int          ACC2_LSB       = 11;
  localparam int          ACC1_LSB       = 8;
  localparam int          THR_LSB        = 3;
  localparam int          ALIGN_LSB      = 0;
  localparam int          LIM_OT_LSB     = 14;
  localparam int          LIM_LOCK_LSB   = 8;
  localparam int          LIM_SOFT_LSB   = 4;
  localparam int          LIM_HARD_LSB   = 1;
  localparam int          LIM_HRANGE_BIT = 0;
  // time base
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          TICK_MS        = 1;
  localparam int          MS_CYCLES      = CLK_HZ / 1000 * TICK_MS;
  // second-order coefficient, units of 0.0001 Hz/s^2
  localparam logic [19:0] ACC2_FAST [0:7] = '{20'h8B290, 20'h46CD0, 20'h222E0, 20'h10D88,
                                              20'h080E8, 20'h03E80, 20'h019C8, 20'h00000};
  localparam logic [19:0] ACC2_SLOW [0:7] = '{20'h00898, 20'h0044C, 20'h00226, 20'h0010E,
                                              20'h00082, 20'h0003F, 20'h0001F, 20'h00000};
  // first-order coefficient, units of 0.001 Hz/s
  localparam logic [16:0] ACC1_FAST [0:7] = '{17'h128E0, 17'h09470, 17'h04A38, 17'h023F0,
                                              17'h01130, 17'h00834, 17'h00384, 17'h0012C};
  localparam logic [16:0] ACC1_SLOW [0:7] = '{17'h012C0, 17'h00960, 17'h004B0, 17'h00244,
                                              17'h0010E, 17'h00082, 17'h0003A, 17'h00013};
  // align time in ms
  localparam logic [12:0] ALIGN_MS [0:7]  = '{13'h14B4, 13'h0A8C, 13'h0514, 13'h029E,
                                              13'h014A, 13'h00A0, 13'h0050, 13'h0028};
  localparam logic [11:0] THR_LO_STEP    = 12'h008;
  localparam logic [11:0] THR_HI_STEP    = 12'h080;
  localparam logic [47:0] SPEED_PER_DHZ  = 48'h00003B9ACA00;
  localparam logic [13:0] ACC1_SCALE     = 14'h2710;
  // currents in mA
  localparam logic [11:0] SOFT_STEP_MA   = 12'h0C8;
  localparam logic [11:0] OT_CAP_MA [0:3] = '{12'h000, 12'h3E8, 12'h640, 12'h7D0};
  localparam logic [11:0] HARD_LO_MA [0:3] = '{12'h9C4, 12'h76C, 12'h5DC, 12'h384};
  localparam logic [11:0] HARD_HI_STEP   = 12'h190;
  typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_RAMP, ST_CLOSED} mst_state_e;
endpackage : mst_pkg

// ===== core/mst_profile_if.sv
// decoded start-up profile settings
`timescale 1ns/1ps
interface mst_profile_if;
  logic [19:0] accel2;
  logic [16:0] accel1;
  logic [11:0] handoverDhz;
  logic [12:0] alignMs;
  modport src (output accel2, output accel1, output handoverDhz, output alignMs);
  modport snk (input accel2, input accel1, input handoverDhz, input alignMs);
endinterface : mst_profile_if

// ===== core/mst_profile_decode.sv
// decodes the start-up profile register into physical settings
`timescale 1ns/1ps
module mst_profile_decode
  import mst_pkg::*;
(
  input  wire logic [15:0] profileReg,
  mst_profile_if.src       prof
);
  logic       slowRange;
  logic [2:0] acc2Code;
  logic [2:0] acc1Code;
  logic [4:0] thrCode;
  logic [2:0] alignCode;

  always_comb begin
    slowRange = profileReg[PROF_RANGE_BIT];
    acc2Code  = profileReg[ACC2_LSB +: 3];
    acc1Code  = profileReg[ACC1_LSB +: 3];
    thrCode   = profileReg[THR_LSB +: 5];
    alignCode = profileReg[ALIGN_LSB +: 3];
    prof.accel2 = slowRange ? ACC2_SLOW[acc2Code] : ACC2_FAST[acc2Code];
    prof.accel1 = slowRange ? ACC1_SLOW[acc1Code] : ACC1_FAST[acc1Code];
    if (thrCode[4]) begin
      prof.handoverDhz = 12'(({8'h00, thrCode[3:0]} + 12'h001) * THR_HI_STEP);
    end else begin
      prof.handoverDhz = 12'({8'h00, thrCode[3:0]} * THR_LO_STEP);
    end
    prof.alignMs = ALIGN_MS[alignCode];
  end
endmodule : mst_profile_decode

// ===== core/mst_limit_decode.sv
// decodes the limit register into current thresholds in mA
`timescale 1ns/1ps
module mst_limit_decode
  import mst_pkg::*;
(
  input  wire logic [15:0] limitReg,
  output logic      [11:0] softMa,
  output logic      [11:0] capMa,
  output logic      [11:0] hardMa
);
  logic [3:0] softCode;
  logic [2:0] hardCode;

  always_comb begin
    softCode = limitReg[LIM_SOFT_LSB +: 4];
    hardCode = limitReg[LIM_HARD_LSB +: 3];
    softMa   = 12'({8'h00, softCode} * SOFT_STEP_MA);
    if (limitReg[LIM_OT_LSB +: 2] == 2'h0) begin
      capMa = softMa;
    end else begin
      capMa = OT_CAP_MA[limitReg[LIM_OT_LSB +: 2]];
    end
    if (limitReg[LIM_HRANGE_BIT]) begin
      hardMa = 12'(({9'h000, hardCode} + 12'h001) * HARD_HI_STEP);
    end else begin
      hardMa = HARD_LO_MA[hardCode[1:0]];
    end
  end
endmodule : mst_limit_decode

// ===== testbench/testbench.sv
// self-checking bench for the start-up profile and limit register bank
`timescale 1ns/1ps
module testbench;
  import mst_pkg::*;
  localparam int T = 4;
  logic        clk;
  logic        resetn;
  logic [7:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWrEn;
  logic        regRdEn;
  logic [15:0] regRdData;
  logic        startReq;
  logic        stopReq;
  logic        alignActive;
  logic        rampActive;
  logic        closedLoop;
  logic [47:0] openLoopSpeed;
  logic [5:0]  lockEnable;
  logic [11:0] softLimitMa;
  logic [11:0] overtempCapMa;
  logic [11:0] hardLimitMa;
  int          errors;
  int          checksDone;
  int          seed;
  logic [15:0] rdVal;
  logic [31:0] rnd;
  int          na;
  int          nr;
  int          nt;

  mst_startup_limit_config #(.TICK_CYCLES(T)) i_dut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .startReq(startReq), .stopReq(stopReq), .alignActive(alignActive),
    .rampActive(rampActive), .closedLoop(closedLoop), .openLoopSpeed(openLoopSpeed),
    .lockEnable(lockEnable), .softLimitMa(softLimitMa), .overtempCapMa(overtempCapMa),
    .hardLimitMa(hardLimitMa)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #5;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #5;
    regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    #5;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    #5;
    regRdEn = 1'b0;
    @(posedge clk);
    #5;
    d = regRdData;
  endtask : rd

  task automatic wrRd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    #5;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #5;
    regWrEn = 1'b0;
    regRdEn = 1'b1;
    @(posedge clk);
    #5;
    regRdEn = 1'b0;
    q = regRdData;
  endtask : wrRd

  function automatic logic [11:0] expSoft(input logic [15:0] r);
    return 12'(r[7:4]) * 12'h0C8;
  endfunction : expSoft

  function automatic logic [11:0] expCap(input logic [15:0] r);
    logic [11:0] t [0:3];
    t = '{expSoft(r), 12'h3E8, 12'h640, 12'h7D0};
    return t[r[15:14]];
  endfunction : expCap

  function automatic logic [11:0] expHard(input logic [15:0] r);
    logic [11:0] t [0:3];
    t = '{12'h9C4, 12'h76C, 12'h5DC, 12'h384};
    return r[0] ? (12'(r[3:1]) + 12'h001) * 12'h190 : t[r[2:1]];
  endfunction : expHard

  // threshold in 0.1 Hz
  function automatic longint expThr(input logic [4:0] c);
    return c[4] ? (longint'(c[3:0]) + 1) * 128 : longint'(c[3:0]) * 8;
  endfunction : expThr

  // ramp ticks until the speed reaches the handover threshold
  function automatic int expTicks(input logic [15:0] p);
    longint a1 = p[14] ? longint'(ACC1_SLOW[p[10:8]]) : longint'(ACC1_FAST[p[10:8]]);
    longint a2 = p[14] ? longint'(ACC2_SLOW[p[13:11]]) : longint'(ACC2_FAST[p[13:11]]);
    longint lim = expThr(p[7:3]) * 1000000000;
    longint s = 0;
    longint sl = 0;
    int n = 0;
    while (s < lim && n < 200000) begin
      s += a1 * 10000 + sl;
      sl += a2;
      n++;
    end
    return n;
  endfunction : expTicks

  task automatic limCase(input logic [15:0] d);
    wr(ADDR_LIMITS, d);
    rd(ADDR_LIMITS, rdVal);
    chk(rdVal, d, "limits readback");
    chk(lockEnable, d[13:8], "lock enables");
    chk(softLimitMa, expSoft(d), "soft limit");
    chk(overtempCapMa, expCap(d), "overtemp cap");
    chk(hardLimitMa, expHard(d), "hard limit");
  endtask : limCase

  task automatic runSeq(input logic [15:0] p);
    wr(ADDR_PROFILE, p);
    rd(ADDR_PROFILE, rdVal);
    chk(rdVal, p & 16'h7FFF, "profile readback");
    @(posedge clk);
    #5;
    startReq = 1'b1;
    @(posedge clk);
    #5;
    startReq = 1'b0;
    na = 0;
    while (alignActive === 1'b1 && na < 30000) begin
      @(posedge clk);
      #5;
      na++;
    end
    chk(na, int'(ALIGN_MS[p[2:0]]) * T, "align length");
    nr = 0;
    while (closedLoop !== 1'b1 && nr < 60000) begin
      @(posedge clk);
      #5;
      nr++;
    end
    nt = expTicks(p) * T;
    chk(nr, nt + 1, "handover time");
    chk({alignActive, rampActive, closedLoop}, 3'b001, "closed loop state");
    @(posedge clk);
    #5;
    startReq = 1'b1;
    @(posedge clk);
    #5;
    chk({alignActive, rampActive, closedLoop}, 3'b001, "start ignored");
    stopReq = 1'b1;
    @(posedge clk);
    #5;
    startReq = 1'b0;
    stopReq = 1'b0;
    chk({alignActive, rampActive, closedLoop}, 3'b000, "stop to idle");
    $display("test sequencer profile %h done", p);
  endtask : runSeq

  initial begin
    #(50 * 100000);
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    seed = 25129;
    resetn = 1'b0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    startReq = 1'b0;
    stopReq = 1'b0;
    errors = 0;
    checksDone = 0;
    repeat (5) @(posedge clk);
    #5;
    resetn = 1'b1;
    rd(ADDR_LIMITS, rdVal);
    chk(rdVal, 16'h0000, "limits reset");
    chk(hardLimitMa, 12'h9C4, "hard limit reset");
    rd(ADDR_PROFILE, rdVal);
    chk(rdVal, 16'h0000, "profile reset");
    wr(8'h95, 16'hFFFF);
    rd(8'h95, rdVal);
    chk(rdVal, 16'h0000, "unmapped read");
    rd(ADDR_LIMITS, rdVal);
    chk(rdVal, 16'h0000, "unmapped write ignored");
    for (int i = 0; i < 16; i++) begin
      limCase({2'(i), 6'h01 << (i % 6), 4'(i), 4'(15 - i)});
    end
    repeat (20) begin
      rnd = $random(seed);
      limCase(rnd[15:0]);
    end
    rnd = $random(seed);
    wrRd(ADDR_LIMITS, rnd[15:0], rdVal);
    chk(rdVal, rnd[15:0], "back to back readback");
    $display("test limits done");
    wr(ADDR_PROFILE, 16'hFFFF);
    rd(ADDR_PROFILE, rdVal);
    chk(rdVal, 16'h7FFF, "reserved bit");
    runSeq(16'h80FF);
    runSeq(16'h400F);
    runSeq(16'h3E0E);
    runSeq(16'h0007);
    repeat (2) begin
      rnd = $random(seed);
      runSeq({3'b000, rnd[1:0], rnd[4:2], 1'b0, rnd[8:5], 3'b111});
    end
    results();
  end
endmodule : testbench
